// ==== lstm_checker.sv ====
// Assertions on the lock and pass outputs.
module lstm_checker (
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire logic                     pll_locked,
  input wire logic                     self_test_select,
  input wire lstm_pkg::lstm_selftest_t selftest,
  input wire logic                     lock,
  input wire logic                     phy_out_enable,
  input wire logic                     pass
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_lock_on: assert property (pll_locked [*6] |-> lock) else $error("lock");
  a_lock_off: assert property (!pll_locked [*6] |-> !lock) else $error("unlock");
  a_phy_on: assert property (lock |-> phy_out_enable) else $error("phy on");
  a_phy_off: assert property (!lock |-> !phy_out_enable) else $error("phy off");
  a_idle_hi: assert property ((!lock && !self_test_select) [*8] |-> pass)
    else $error("idle");
  a_flt_lock: assert property ($fell(pass) && !self_test_select |-> $past(lock))
    else $error("fault");
  a_st_err: assert property (self_test_select [*6] ##0 selftest.error |=> !pass)
    else $error("st err");
  a_st_ok: assert property (self_test_select [*6] ##0 !selftest.error |=> pass)
    else $error("st ok");
  cover property ($rose(lock));
  cover property (!self_test_select && $fell(pass));
  cover property (self_test_select && $fell(pass));
endmodule

bind lstm_monitor lstm_checker lstm_checker_i (.clk, .sys_rst, .pll_locked, .self_test_select,
  .selftest, .lock, .phy_out_enable, .pass);

// ==== lstm_host.sv ====
// Host model that counts faults shown on the pass pin.
module lstm_host (
  input wire logic clk,
  input wire logic lock,
  input wire logic pass,
  output int       faults
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts each fall of pass while the link is locked.
  always_ff @(posedge clk)
    if (lock && $past(pass) && !pass)
      faults <= faults + 1;
endmodule

// ==== lstm_monitor.sv ====
// Lock and pass status output logic with display timing checker.

// Notes on behaviour
// - Lock high when PLL locked, else low.
// - Serial outputs kept active while lock high.
// - Normal mode: pass high while timing good.
// - Normal mode: pass low on timing fault.
// - One active-video length mismatch is a fault.
// - Vsync fault needs two consecutive mismatches.
// - Self-test mode: pass shows self-test result.
module lstm_monitor #(
  parameter int unsigned CNT_W = lstm_pkg::CNT_W
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    pll_locked,
  input  wire logic                    self_test_select,
  input  wire lstm_pkg::lstm_timing_t  timing,
  input  wire lstm_pkg::lstm_selftest_t selftest,
  output logic                         lock,
  output logic                         phy_out_enable,
  output logic                         pass
);

  logic [2:0]       lock_sync_q;
  logic [2:0]       mode_sync_q;
  logic [2:0]       av_sync_q;
  logic [2:0]       vs_sync_q;
  logic             lock_q;
  logic             mode_q;
  logic             av_q;
  logic             vs_q;
  logic             av_rise;
  logic             av_fall;
  logic             vs_rise;
  logic             vs_fall;
  logic             av_first_fall;
  logic             av_check;
  logic             vs_check;
  logic             vs_mismatch;
  logic [CNT_W-1:0] av_cnt_q;
  logic [CNT_W-1:0] vs_cnt_q;
  logic [CNT_W-1:0] av_ref_q;
  logic [CNT_W-1:0] vs_ref_q;
  logic             av_ref_ok_q;
  logic             vs_ref_ok_q;
  logic             av_seen_q;
  logic [1:0]       vs_miss_q;
  logic             timing_fault_q;
  logic             pass_q;

  // Three-stage synchronisers on pll_locked, self_test_select and both timing pins; the selftest inputs are used unsynchronised.
  // Only the second stage reads the first, so a metastable first stage never fans out.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lock_sync_q <= 3'h0;
      mode_sync_q <= 3'h0;
      av_sync_q   <= 3'h0;
      vs_sync_q   <= 3'h0;
    end
    else
    begin
      lock_sync_q <= {lock_sync_q[1:0], pll_locked};
      mode_sync_q <= {mode_sync_q[1:0], self_test_select};
      av_sync_q   <= {av_sync_q[1:0], timing.active_video_flag};
      vs_sync_q   <= {vs_sync_q[1:0], timing.vsync};
    end
  end

  // Filtered levels follow only when the last two stages agree.
  // A one-cycle glitch that reaches only one of the two stages is ignored.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lock_q <= lstm_pkg::LOCK_RST;
      mode_q <= 1'h0;
      av_q   <= 1'h0;
      vs_q   <= 1'h0;
    end
    else
    begin
      if (lock_sync_q[1] == lock_sync_q[2]) lock_q <= lock_sync_q[2];
      if (mode_sync_q[1] == mode_sync_q[2]) mode_q <= mode_sync_q[2];
      if (av_sync_q[1] == av_sync_q[2]) av_q <= av_sync_q[2];
      if (vs_sync_q[1] == vs_sync_q[2]) vs_q <= vs_sync_q[2];
    end
  end

  // Edge strobes are high in the cycle before the filtered level changes.
  // Filtered levels reset to the idle low of the pins, so reset gives no false edge.
  assign av_rise = av_sync_q[2] && av_sync_q[1] && !av_q;
  assign av_fall = !av_sync_q[2] && !av_sync_q[1] && av_q;
  assign vs_rise = vs_sync_q[2] && vs_sync_q[1] && !vs_q;
  assign vs_fall = !vs_sync_q[2] && !vs_sync_q[1] && vs_q;

  // Compare strobes: first active-video line of a frame, and every vsync end.
  assign av_first_fall = av_fall && !av_seen_q;
  assign av_check      = av_first_fall && av_ref_ok_q;
  assign vs_check      = vs_fall && vs_ref_ok_q;
  assign vs_mismatch   = vs_cnt_q != vs_ref_q;

  // Interval length counters saturate rather than wrap.
  // A saturated count still compares equal to a saturated reference.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      av_cnt_q <= '0;
      vs_cnt_q <= '0;
    end
    else
    begin
      if (av_rise)
        av_cnt_q <= CNT_W'(1);
      else if (av_q && !(&av_cnt_q))
        av_cnt_q <= av_cnt_q + CNT_W'(1);
      if (vs_rise)
        vs_cnt_q <= CNT_W'(1);
      else if (vs_q && !(&vs_cnt_q))
        vs_cnt_q <= vs_cnt_q + CNT_W'(1);
    end
  end

  // Active-video reference: the first line after each vsync rise is kept.
  // Only that line is measured, so lines of unequal length within a frame are fine.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      av_ref_q    <= '0;
      av_ref_ok_q <= 1'h0;
      av_seen_q   <= 1'h0;
    end
    else if (!lock_q)
    begin
      av_ref_ok_q <= 1'h0; // Without lock the timing history is meaningless.
      av_seen_q   <= 1'h0;
    end
    else
    begin
      if (vs_rise)
        av_seen_q <= 1'h0;
      else if (av_fall)
        av_seen_q <= 1'h1;
      if (av_first_fall)
      begin
        av_ref_q    <= av_cnt_q;
        av_ref_ok_q <= 1'h1;
      end
    end
  end

  // Vsync reference follows every frame.
  // A lasting new vsync length therefore misses once and then matches.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vs_ref_q    <= '0;
      vs_ref_ok_q <= 1'h0;
    end
    else if (!lock_q)
      vs_ref_ok_q <= 1'h0;
    else if (vs_fall)
    begin
      vs_ref_q    <= vs_cnt_q;
      vs_ref_ok_q <= 1'h1;
    end
  end

  // Vsync miss counter: mismatches in a row, saturating at the limit.
  // A matching length starts the count again.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      vs_miss_q <= lstm_pkg::VS_MISS_RST;
    else if (!lock_q)
      vs_miss_q <= lstm_pkg::VS_MISS_RST;
    else if (vs_check)
    begin
      if (!vs_mismatch)
        vs_miss_q <= lstm_pkg::VS_MISS_RST;
      else if (vs_miss_q != lstm_pkg::VS_MISS_LIMIT)
        vs_miss_q <= vs_miss_q + 2'h1;
    end
  end

  // Fault flag: a second vsync miss in a row sets it, and so does every further one.
  // The set takes priority over an active-video check in the same cycle.
  // An active-video check otherwise loads the flag with its own result.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      timing_fault_q <= 1'h0;
    else if (!lock_q)
      timing_fault_q <= 1'h0;
    else if (vs_check && vs_mismatch && (vs_miss_q >= lstm_pkg::VS_MISS_LIMIT - 2'h1))
      timing_fault_q <= 1'h1;
    else if (av_check)
      timing_fault_q <= (av_cnt_q != av_ref_q);
  end

  // Pass output selects between timing check and self-test result.
  // A fault left from before the link dropped is masked at once, not a cycle late.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pass_q <= lstm_pkg::PASS_RST;
    else if (mode_q)
      pass_q <= !selftest.error;
    else
      pass_q <= !(timing_fault_q && lock_q);
  end

  // Status pins are driven straight from flip-flops.
  assign lock           = lock_q;
  assign phy_out_enable = lock_q;
  assign pass           = pass_q;

endmodule

// ==== lstm_pkg.sv ====
// Package with constants and carrier types for the link status and timing monitor.
package lstm_pkg;

  // Width in bits of the interval length counters, which count clock cycles.
  localparam int unsigned CNT_W = 24;

  // Value of each status output and of the vsync miss counter while reset is applied.
  localparam logic LOCK_RST = 1'h0;
  localparam logic PASS_RST = 1'h1;
  localparam logic [1:0] VS_MISS_RST = 2'h0;

  // Number of vertical-sync mismatches in a row that count as a fault.
  localparam logic [1:0] VS_MISS_LIMIT = 2'h2;

  // Raw video timing inputs, grouped as they arrive.
  typedef struct packed {
    logic active_video_flag;
    logic vsync;
  } lstm_timing_t;

  // Self-test result inputs.
  typedef struct packed {
    logic done;
    logic error;
  } lstm_selftest_t;

endpackage

// ==== test_link_status_timing_monitor.sv ====
// Bench of the status monitor.
module test_link_status_timing_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'h0, sys_rst = 1'h1, pll_locked = 1'h0;
  logic                     self_test_select = 1'h0, f = 1'h0;
  logic                     lock, phy_out_enable, pass;
  lstm_pkg::lstm_timing_t   timing = '0;
  lstm_pkg::lstm_selftest_t selftest = '0;
  logic [31:0]              rs = 32'hF822;
  int                       err_count = 0, check_count = 0, faults, vm, pv = -1, pd = -1;
  int                       vt[6] = '{10, 10, 11, 12, 12, 12};
  always #2.5 clk = ~clk;
  lstm_monitor lstm_monitor_i (.clk, .sys_rst, .pll_locked, .self_test_select, .timing,
    .selftest, .lock, .phy_out_enable, .pass);
  lstm_host lstm_host_i (.clk, .lock, .pass, .faults);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(logic s, logic e);
    check_count++;
    err_count += int'(s !== e);
    if (s !== e)
      $display("ERROR %0t: pin %b", $time, s);
  endtask
  task automatic wrap_up;
    $display("%0d errors in %0d checks", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Waits n edges and compares pass with the model at the falling edge.
  task automatic pchk(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk(pass, !f);
    @(posedge clk);
  endtask
  // Sends one frame; the miss count and fault flag give the expected pass level.
  task automatic frame(int v, int d);
    timing.vsync <= 1'h1;
    repeat (v) @(posedge clk);
    timing.vsync <= 1'h0;
    vm = (pv < 0 || v == pv) ? 0 : vm + 1;
    f |= vm > 1;
    pchk(12);
    timing.active_video_flag <= 1'h1;
    repeat (d) @(posedge clk);
    timing.active_video_flag <= 1'h0;
    f = pd >= 0 && d != pd;
    pchk(12);
    pv = v;
    pd = d;
  endtask
  // Lock, fixed and random frames, self-test, then unlock.
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    pll_locked <= 1'h1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(phy_out_enable, 1'h1);
    @(posedge clk);
    for (int i = 0; i < 14; i++)
    begin
      rs = xs(rs);
      frame(i < 6 ? vt[i] : 8 + rs[1:0], i == 5 ? 8 : 9 + (i > 5) * rs[5:4]);
    end
    self_test_select <= 1'h1;
    for (int i = 0; i < 20; i++)
    begin
      rs = xs(rs);
      selftest <= rs[1:0];
      f = rs[0];
      pchk(i ? 1 : 6);
    end
    self_test_select <= 1'h0;
    pll_locked <= 1'h0;
    f = 0;
    pchk(8);
    chk(lock | (faults == 0), 1'h0);
    wrap_up;
  end
  // Cuts a hung run short.
  initial
  begin
    #80us;
    err_count++;
    wrap_up;
  end
endmodule
